// file: design/deser_port_select.sv
// Receive mode, strap handling, 2:1 input select and parallel output
`timescale 1ns/1ps
module deser_port_select
   import deser_pkg::*;
(
   input  wire logic                          sys_clk,
   input  wire logic                          reset,
   input  wire logic [7:0]                    reg_addr,
   input  wire logic [7:0]                    reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic [7:0]                         reg_rdata,
   input  wire logic [2:0]                    mode_strap,
   input  wire logic                          port_sel_pin,
   input  wire logic [deser_pkg::FRAME_W-1:0] rx0_frame,
   input  wire logic                          rx0_vld,
   input  wire logic [deser_pkg::FRAME_W-1:0] rx1_frame,
   input  wire logic                          rx1_vld,
   output logic [deser_pkg::PIX_W-1:0]        pix_data,
   output logic                               pix_hsync,
   output logic                               pix_vsync,
   output logic                               pix_vld,
   output logic [1:0]                         bc_en,
   output logic [1:0]                         bc_data,
   output logic                               coax_mode,
   output logic                               active_port
);
   localparam logic [2:0] GAP_MIN = 3'(MIN_FRAME_GAP_CYC);

   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   typedef struct packed {
      logic       sel_s1;
      logic       sel_s2;
      logic [2:0] strap_s1;
      logic [2:0] strap_s2;
      logic [1:0] settle;
      logic       strap_done;
      logic       strap_rsvd;
      logic [2:0] cfg;
      logic [2:0] ctrl;
      logic [1:0] bc_tx;
      logic       active;
      logic [1:0] bc_en;
      logic [2:0] gap;
      logic       rate_err;
      logic       ovf_err;
      logic [7:0] err_cnt;
      logic [1:0] cch;
      logic       cch_new;
      logic [7:0] rdata;
   } top_t;
   top_t st_r, st_nxt;

   logic [FRAME_W-1:0] sel_frame;
   logic               sel_vld;
   logic               regen_ovf;
   payload_if          pay ();

   function automatic logic [1:0] strap_width(input logic [1:0] code);
      logic [1:0] w;
      w = 2'(W_SLOW);
      unique case (code)
         2'h1: w = 2'(W_SLOW);
         2'h2: w = 2'(W_FAST);
         2'h3: w = 2'(W_TEN);
         2'h0: w = 2'(W_SLOW);
      endcase
      return w;
   endfunction

   //------------------------------------------------------------
   // Input select
   //------------------------------------------------------------
   // Mux sits ahead of the descrambler, so a switch garbles one frame
   assign sel_frame = st_r.active ? rx1_frame : rx0_frame;
   assign sel_vld   = st_r.active ? rx1_vld : rx0_vld;

   frame_unscrambler u_unscr (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .frame_vld (sel_vld),
      .frame     (sel_frame),
      .pay       (pay.src)
   );

   pixel_regen u_regen (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .mode      (width_mode_t'(st_r.cfg[1:0])),
      .pay       (pay.snk),
      .pix_data  (pix_data),
      .pix_hsync (pix_hsync),
      .pix_vsync (pix_vsync),
      .pix_vld   (pix_vld),
      .overflow  (regen_ovf)
   );

   //------------------------------------------------------------
   // Next state
   //------------------------------------------------------------
   always_comb
   begin
      st_nxt          = st_r;
      st_nxt.sel_s1   = port_sel_pin;
      st_nxt.sel_s2   = st_r.sel_s1;
      st_nxt.strap_s1 = mode_strap;
      st_nxt.strap_s2 = st_r.strap_s1;
      st_nxt.rdata    = 8'h00;

      // Strap taken once after the synchroniser has settled
      if (!st_r.strap_done)
      begin
         if (st_r.settle == STRAP_SETTLE)
         begin
            st_nxt.strap_done = 1'b1;
            st_nxt.strap_rsvd = (st_r.strap_s2[1:0] == 2'h0);
            if (st_r.strap_s2[1:0] != 2'h0)
            begin
               st_nxt.cfg = {st_r.strap_s2[2], strap_width(st_r.strap_s2[1:0])};
            end
         end
         else
         begin
            st_nxt.settle = st_r.settle + 2'h1;
         end
      end

      // Register writes, after the strap load so software wins
      if (reg_wr)
      begin
         unique case (reg_addr)
            PORT_CFG_ADDR: st_nxt.cfg = reg_wdata[2:0];
            CTRL_ADDR:     st_nxt.ctrl = reg_wdata[2:0];
            CCH_TX_ADDR:   st_nxt.bc_tx = reg_wdata[1:0];
            default:       st_nxt.ctrl = st_r.ctrl;
         endcase
      end

      // Port choice and back channel
      st_nxt.active = st_r.ctrl[CTRL_OVR_BIT] ? st_r.ctrl[CTRL_SEL_BIT] : st_r.sel_s2;
      if (!st_r.ctrl[CTRL_BC_BIT])
         st_nxt.bc_en = 2'h0;
      else if (st_nxt.active)
         st_nxt.bc_en = 2'h2;
      else
         st_nxt.bc_en = 2'h1;

      // Frame spacing against the line-rate ceiling
      if (sel_vld)
         st_nxt.gap = 3'h0;
      else if (st_r.gap < GAP_MIN)
         st_nxt.gap = st_r.gap + 3'h1;

      // Clear-on-read first so a same-cycle event survives
      if (reg_rd && reg_addr == STATUS_ADDR)
      begin
         st_nxt.rate_err = 1'b0;
         st_nxt.ovf_err  = 1'b0;
      end
      if (reg_rd && reg_addr == CCH_RX_ADDR)
         st_nxt.cch_new = 1'b0;

      if (sel_vld && (st_r.gap + 3'h1) < GAP_MIN)
         st_nxt.rate_err = 1'b1;
      if (regen_ovf)
         st_nxt.ovf_err = 1'b1;
      if (pay.valid)
      begin
         st_nxt.cch     = pay.ctl;
         st_nxt.cch_new = 1'b1;
         if (pay.par_err && st_r.err_cnt != 8'hFF)
            st_nxt.err_cnt = st_r.err_cnt + 8'h01;
      end

      // Read data, one cycle after the strobe
      if (reg_rd)
      begin
         unique case (reg_addr)
            PORT_CFG_ADDR: st_nxt.rdata = {5'h00, st_r.cfg};
            CTRL_ADDR:     st_nxt.rdata = {5'h00, st_r.ctrl};
            STATUS_ADDR:
               st_nxt.rdata = {3'h0, st_r.ovf_err, st_r.rate_err,
                               st_r.strap_rsvd, st_r.strap_done, st_r.active};
            ERRCNT_ADDR:   st_nxt.rdata = st_r.err_cnt;
            CCH_RX_ADDR:   st_nxt.rdata = {5'h00, st_r.cch_new, st_r.cch};
            CCH_TX_ADDR:   st_nxt.rdata = {6'h00, st_r.bc_tx};
            default:       st_nxt.rdata = 8'h00;
         endcase
      end
   end

   //------------------------------------------------------------
   // Registers
   //------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         st_r      <= '0;
         st_r.cfg  <= CFG_RST;
         st_r.ctrl <= CTRL_RST;
         st_r.gap  <= GAP_MIN;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata   = st_r.rdata;
   assign bc_en       = st_r.bc_en;
   assign bc_data     = st_r.bc_tx;
   assign coax_mode   = st_r.cfg[CFG_COAX_BIT];
   assign active_port = st_r.active;

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence strap_release_s;
      !st_r.strap_done ##1 st_r.strap_done;
   endsequence

   sequence ctrl_reg_sel1_s;
      reg_wr && reg_addr == CTRL_ADDR && reg_wdata[1:0] == 2'h3 ##1 !reg_wr;
   endsequence

   back_chan_sel_a: assert property (
      bc_en != 2'h0 |-> $onehot(bc_en) && bc_en[active_port])
      else $error("back channel not on the selected port");

   mux_valid_a: assert property (
      pay.valid |-> $past(active_port ? rx1_vld : rx0_vld))
      else $error("payload from a port that was not selected");

   strap_load_a: assert property (
      strap_release_s ##0 $past(st_r.strap_s2[1:0]) != 2'h0
      |-> coax_mode == $past(st_r.strap_s2[2])
          && st_r.cfg[1:0] == 2'($past(st_r.strap_s2[1:0]) - 2'h1))
      else $error("strap not loaded into configuration");

   strap_rsvd_a: assert property (
      strap_release_s ##0 $past(st_r.strap_s2[1:0]) == 2'h0
      |-> st_r.cfg == $past(st_r.cfg) && st_r.strap_rsvd)
      else $error("reserved strap changed configuration");

   pin_select_a: assert property (
      !st_r.ctrl[CTRL_OVR_BIT] && st_r.sel_s2 ##1 !st_r.ctrl[CTRL_OVR_BIT]
      |-> active_port)
      else $error("select pin not followed");

   reg_select_a: assert property (
      ctrl_reg_sel1_s |-> ##1 active_port)
      else $error("register select not followed");

   cfg_write_a: assert property (
      reg_wr && reg_addr == PORT_CFG_ADDR && st_r.strap_done
      |=> coax_mode == $past(reg_wdata[2]) ##1 reg_rdata[2] == coax_mode || !$past(reg_rd))
      else $error("configuration write lost");

   rate_err_a: assert property (
      sel_vld ##1 sel_vld && !(reg_rd && reg_addr == STATUS_ADDR)
      |=> st_r.rate_err)
      else $error("back to back frames not flagged");
endmodule // deser_port_select

// file: design/frame_unscrambler.sv
// Self-synchronising descrambler with DC-balance undo and parity check
`timescale 1ns/1ps
module frame_unscrambler
   import deser_pkg::*;
(
   input  wire logic                        sys_clk,
   input  wire logic                        reset,
   input  wire logic                        frame_vld,
   input  wire logic [deser_pkg::FRAME_W-1:0] frame,
   payload_if.src                           pay
);
   localparam int HALF = FRAME_W / 2;
   typedef struct packed {
      logic [FRAME_W-1:0] prev;
      logic               vld;
      logic [PAY_W-1:0]   data;
      logic [1:0]         ctl;
      logic               perr;
   } unscr_t;
   unscr_t st_r, st_nxt;
   logic [FRAME_W-1:0] d;

   always_comb
   begin
      st_nxt     = st_r;
      st_nxt.vld = frame_vld;
      d          = frame ^ {st_r.prev[HALF-1:0], st_r.prev[FRAME_W-1:HALF]};
      if (d[FR_INV_BIT])
      begin
         d[FR_PAR_BIT-1:0] = ~d[FR_PAR_BIT-1:0];
      end
      if (frame_vld)
      begin
         st_nxt.prev = frame;
         st_nxt.data = d[PAY_W-1:0];
         st_nxt.ctl  = d[FR_CTL_LSB+1:FR_CTL_LSB];
         st_nxt.perr = ^d[FR_PAR_BIT:0];
      end
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign pay.valid   = st_r.vld;
   assign pay.data    = st_r.data;
   assign pay.ctl     = st_r.ctl;
   assign pay.par_err = st_r.perr;
endmodule // frame_unscrambler

// file: design/pixel_regen.sv
// Rebuilds pixels from frame payload at the ratio set by the width mode
`timescale 1ns/1ps
module pixel_regen
   import deser_pkg::*;
(
   input  wire logic                      sys_clk,
   input  wire logic                      reset,
   input  wire deser_pkg::width_mode_t    mode,
   payload_if.snk                         pay,
   output logic [deser_pkg::PIX_W-1:0]    pix_data,
   output logic                           pix_hsync,
   output logic                           pix_vsync,
   output logic                           pix_vld,
   output logic                           overflow
);
   typedef struct packed {
      logic [47:0]      acc;
      logic [5:0]       cnt;
      width_mode_t      mode;
      logic [PIX_W-1:0] data;
      logic             hs;
      logic             vs;
      logic             vld;
      logic             ovf;
   } regen_t;
   regen_t st_r, st_nxt;
   logic [5:0]  ppw;
   logic [5:0]  fw;
   logic [47:0] fresh;

   always_comb
   begin
      st_nxt     = st_r;
      st_nxt.vld = 1'b0;
      st_nxt.ovf = 1'b0;
      ppw        = 6'h0E;
      fw         = 6'h0E;
      unique case (mode)
         W_FAST: fw = 6'h15;
         W_TEN:
         begin
            ppw = 6'h0C;
            fw  = 6'h18;
         end
         W_SLOW, W_RSVD: fw = 6'h0E;
      endcase
      if (mode != st_r.mode)
      begin
         st_nxt.acc  = '0;
         st_nxt.cnt  = '0;
         st_nxt.mode = mode;
      end
      else if (st_r.cnt >= ppw)
      begin
         st_nxt.vld = 1'b1;
         st_nxt.data = (mode == W_TEN) ? {2'h0, st_r.acc[9:0]} : st_r.acc[11:0];
         st_nxt.hs   = (mode == W_TEN) ? st_r.acc[10] : st_r.acc[12];
         st_nxt.vs   = (mode == W_TEN) ? st_r.acc[11] : st_r.acc[13];
         st_nxt.acc  = st_r.acc >> ppw;
         st_nxt.cnt  = st_r.cnt - ppw;
      end
      fresh = 48'(pay.data & 24'((25'h1 << fw) - 25'h1)) << st_nxt.cnt;
      if (pay.valid && mode == st_r.mode)
      begin
         if (7'(st_nxt.cnt) + 7'(fw) > 7'h30)
            st_nxt.ovf = 1'b1;
         else
         begin
            st_nxt.acc = st_nxt.acc | fresh;
            st_nxt.cnt = st_nxt.cnt + fw;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign pix_data  = st_r.data;
   assign pix_hsync = st_r.hs;
   assign pix_vsync = st_r.vs;
   assign pix_vld   = st_r.vld;
   assign overflow  = st_r.ovf;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   ten_two_pix_a: assert property (
      pay.valid && mode == W_TEN && st_r.mode == W_TEN && st_r.cnt == 6'h00
      |-> ##2 pix_vld ##1 pix_vld)
      else $error("ten-bit frame did not give two pixels");
endmodule // pixel_regen

// file: pkg/deser_pkg.sv
// Shared constants and types for the port select and mode block
//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------
// Overview of operation
// - Forward frames carry 28 bits each
// - Receiver undoes scrambling and DC-balance inversion
// - Fast twelve-bit: 12 data plus 2 sync
// - Ten-bit mode: 10 data plus 2 sync
// - Slow twelve-bit: 12 data plus 2 sync
// - Regenerate pixels at ratio 1.5, 2, 1
// - Line rate follows mode ratio times 28
// - Line rate never exceeds 1.867 Gbps
// - Two-to-one mux, one input active
// - Select by pin or by register
// - Back channel on for selected port only
// - Selected stream drives parallel output bus
// - Output stays parallel in every mode
// - Strap sets mode, register bits 1:0 override
// - Strap codes 0 and 4 reserved, six usable
// - Strap sets medium and width independently
// - Config register bit 2 medium, bits 1:0 width
// - Control channel full duplex beside video
// - Control channel reachable from local host port
package deser_pkg;
   //------------------------------------------------------------
   // Frame layout
   //------------------------------------------------------------
   localparam int FRAME_W    = 28;
   localparam int PAY_W      = 24;
   localparam int PIX_W      = 12;
   localparam int FR_INV_BIT = 27;
   localparam int FR_PAR_BIT = 26;
   localparam int FR_CTL_LSB = 24;
   //------------------------------------------------------------
   // Register map
   //------------------------------------------------------------
   localparam logic [7:0] CTRL_ADDR     = 8'h01;
   localparam logic [7:0] STATUS_ADDR   = 8'h02;
   localparam logic [7:0] ERRCNT_ADDR   = 8'h03;
   localparam logic [7:0] CCH_RX_ADDR   = 8'h04;
   localparam logic [7:0] CCH_TX_ADDR   = 8'h05;
   localparam logic [7:0] PORT_CFG_ADDR = 8'h6D;
   localparam int CFG_COAX_BIT = 2;
   localparam int CTRL_OVR_BIT = 0;
   localparam int CTRL_SEL_BIT = 1;
   localparam int CTRL_BC_BIT  = 2;
   localparam logic [2:0] CFG_RST  = 3'h4;
   localparam logic [2:0] CTRL_RST = 3'h4;
   //------------------------------------------------------------
   // Timing
   //------------------------------------------------------------
   localparam int SYS_CLK_KHZ   = 125000;
   localparam int LINE_MAX_KBPS = 1867000;
   localparam int MIN_FRAME_GAP_CYC =
      (SYS_CLK_KHZ * FRAME_W + LINE_MAX_KBPS - 1) / LINE_MAX_KBPS;
   localparam logic [1:0] STRAP_SETTLE = 2'h3;
   typedef enum logic [1:0] {W_SLOW, W_FAST, W_TEN, W_RSVD} width_mode_t;
endpackage

// file: pkg/payload_if.sv
// Descrambled frame payload between the unscrambler and pixel rebuild
`timescale 1ns/1ps
interface payload_if;
   logic        valid;
   logic [23:0] data;
   logic [1:0]  ctl;
   logic        par_err;
   modport src (output valid, data, ctl, par_err);
   modport snk (input valid, data, ctl, par_err);
endinterface

// file: verif/deser_port_select_tb_top.sv
// Self-checking bench for the port select and mode block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin mismatches++; \
   $display("mismatch %s exp %0h got %0h", nm, ex, gt); end end
module deser_port_select_tb_top;
   import deser_pkg::*;

   logic        sys_clk;
   logic        reset;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic [2:0]  mode_strap;
   logic        port_sel_pin;
   logic [27:0] rx0_frame;
   logic        rx0_vld;
   logic [27:0] rx1_frame;
   logic        rx1_vld;
   logic [11:0] pix_data;
   logic        pix_hsync;
   logic        pix_vsync;
   logic        pix_vld;
   logic [1:0]  bc_en;
   logic [1:0]  bc_data;
   logic        coax_mode;
   logic        active_port;
   logic [1:0]  send;
   logic [23:0] payload;
   logic [1:0]  ctl;
   logic [7:0]  rd;
   logic [13:0] got_q[$];
   int          mismatches;
   int          tests_run;

   deser_port_select uut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mode_strap(mode_strap), .port_sel_pin(port_sel_pin), .rx0_frame(rx0_frame),
      .rx0_vld(rx0_vld), .rx1_frame(rx1_frame), .rx1_vld(rx1_vld), .pix_data(pix_data),
      .pix_hsync(pix_hsync), .pix_vsync(pix_vsync), .pix_vld(pix_vld), .bc_en(bc_en),
      .bc_data(bc_data), .coax_mode(coax_mode), .active_port(active_port));
   serializer_model ser0 (.sys_clk(sys_clk), .reset(reset), .send(send[0]),
      .payload(payload), .ctl(ctl), .frame(rx0_frame), .vld(rx0_vld));
   serializer_model ser1 (.sys_clk(sys_clk), .reset(reset), .send(send[1]),
      .payload(payload), .ctl(ctl), .frame(rx1_frame), .vld(rx1_vld));

   initial sys_clk = 1'b0;
   always #4 sys_clk = ~sys_clk;

   // Taken mid-cycle, clear of the edge that launches the pixel
   always @(negedge sys_clk)
      if (pix_vld === 1'b1)
         got_q.push_back({pix_vsync, pix_hsync, pix_data});

   //--------------------
   // Bus and link tasks
   //--------------------
   task automatic do_reset(input logic [2:0] code);
      @(posedge sys_clk);
      mode_strap <= code;
      reset      <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (8) @(posedge sys_clk);
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // Sync bits stay low in every ten-bit payload except 24'h155555 sent to the idle port 0, well inside the toggle limit
   task automatic send_frame(input int p, input logic [23:0] d);
      @(posedge sys_clk);
      payload <= d;
      send[p] <= 1'b1;
      @(posedge sys_clk);
      send <= 2'b00;
      @(posedge sys_clk);
   endtask

   task automatic chk_pix(input logic [13:0] e);
      logic [13:0] g;
      g = {14{1'bx}};
      for (int i = 0; i < 40 && got_q.size() == 0; i++) @(posedge sys_clk);
      if (got_q.size() > 0) g = got_q.pop_front();
      `CHK("pixel", e, g)
   endtask

   //--------------------
   // Scenarios
   //--------------------
   task automatic t_strap();
      logic [2:0] cc;
      logic [2:0] e;
      for (int c = 0; c < 8; c++)
      begin
         cc = 3'(c);
         e = (cc == 3'h0 || cc == 3'h4) ? CFG_RST : {cc[2], cc[1:0] - 2'h1};
         do_reset(cc);
         reg_read(PORT_CFG_ADDR, rd);
         `CHK("port_cfg", {5'h00, e}, rd)
         `CHK("coax_mode", e[2], coax_mode)
         reg_read(STATUS_ADDR, rd);
         `CHK("status", {5'h00, (cc[1:0] == 2'h0), 2'b10}, rd)
      end
   endtask

   task automatic t_defaults();
      do_reset(3'h5);
      `CHK("active_port", 1'b0, active_port)
      `CHK("bc_en", 2'b01, bc_en)
      reg_read(CTRL_ADDR, rd);
      `CHK("ctrl", {5'h00, CTRL_RST}, rd)
      reg_write(8'h7F, 8'hFF);
      reg_read(8'h7F, rd);
      `CHK("unmapped", 8'h00, rd)
   endtask

   task automatic t_modes();
      logic [41:0] s;
      // Strapped slow mode decides the width until software overrides it
      send_frame(0, 24'h002ABC);
      chk_pix(14'h2ABC);
      reg_read(CCH_RX_ADDR, rd);
      `CHK("cch_rx", 8'h05, rd)
      // Width code 3 is not a mode of its own and falls back to slow
      reg_write(PORT_CFG_ADDR, 8'h07);
      ctl <= 2'h2;
      send_frame(0, 24'h001234);
      chk_pix(14'h1234);
      reg_read(CCH_RX_ADDR, rd);
      `CHK("cch_rx", 8'h06, rd)
      reg_write(PORT_CFG_ADDR, 8'h01);
      reg_read(PORT_CFG_ADDR, rd);
      `CHK("port_cfg", 8'h01, rd)
      `CHK("coax_mode", 1'b0, coax_mode)
      s = {14'h0ACE, 14'h2F0E, 14'h1234};
      send_frame(0, {3'h0, s[20:0]});
      send_frame(0, {3'h0, s[41:21]});
      chk_pix(14'h1234);
      chk_pix(14'h2F0E);
      chk_pix(14'h0ACE);
      reg_write(PORT_CFG_ADDR, 8'hFA);
      reg_read(PORT_CFG_ADDR, rd);
      `CHK("port_cfg", 8'h02, rd)
      send_frame(0, 24'h3A31C7);
      chk_pix(14'h01C7);
      chk_pix(14'h03A3);
      reg_read(ERRCNT_ADDR, rd);
      `CHK("par_errs", 8'h00, rd)
   endtask

   task automatic t_rate();
      // Four adjacent frames break the line ceiling and overfill the pixel store
      @(posedge sys_clk);
      payload <= 24'h000000;
      send[0] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      send <= 2'b00;
      repeat (3) @(posedge sys_clk);
      reg_read(STATUS_ADDR, rd);
      `CHK("rate_err", 8'h18, rd & 8'h18)
      reg_read(STATUS_ADDR, rd);
      `CHK("rate_clr", 8'h00, rd & 8'h18)
      repeat (10) @(posedge sys_clk);
      got_q.delete();
   endtask

   task automatic t_select();
      @(posedge sys_clk);
      port_sel_pin <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 `CHK("active_port", 1'b1, active_port)
      `CHK("bc_en", 2'b10, bc_en)
      send_frame(0, 24'h155555);
      repeat (10) @(posedge sys_clk);
      `CHK("idle_port", 0, got_q.size())
      // Shared descrambler history garbles the first frame after a switch
      send_frame(1, 24'h000000);
      repeat (20) @(posedge sys_clk);
      got_q.delete();
      send_frame(1, 24'h2AB0CD);
      chk_pix(14'h00CD);
      chk_pix(14'h02AB);
      reg_write(CTRL_ADDR, 8'h01);
      repeat (2) @(posedge sys_clk);
      #1 `CHK("active_port", 1'b0, active_port)
      `CHK("bc_en", 2'b00, bc_en)
      reg_write(CTRL_ADDR, 8'h05);
      repeat (2) @(posedge sys_clk);
      #1 `CHK("bc_en", 2'b01, bc_en)
      reg_write(CCH_TX_ADDR, 8'h02);
      repeat (2) @(posedge sys_clk);
      #1 `CHK("bc_data", 2'h2, bc_data)
      reg_read(CCH_TX_ADDR, rd);
      `CHK("cch_tx", 8'h02, rd)
      // Register picks port 1 against a low pin, back channel enabled after
      @(posedge sys_clk);
      port_sel_pin <= 1'b0;
      reg_write(CTRL_ADDR, 8'h03);
      repeat (2) @(posedge sys_clk);
      #1 `CHK("active_port", 1'b1, active_port)
      `CHK("bc_en", 2'b00, bc_en)
      reg_write(CTRL_ADDR, 8'h07);
      repeat (2) @(posedge sys_clk);
      #1 `CHK("bc_en", 2'b10, bc_en)
   endtask

   //--------------------
   // Run control
   //--------------------
   task automatic report_and_stop();
      if (mismatches == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      reset        = 1'b1;
      reg_addr     = 8'h00;
      reg_wdata    = 8'h00;
      reg_wr       = 1'b0;
      reg_rd       = 1'b0;
      mode_strap   = 3'h5;
      port_sel_pin = 1'b0;
      send         = 2'b00;
      payload      = 24'h000000;
      ctl          = 2'h1;
      mismatches   = 0;
      tests_run    = 0;
      t_strap();
      t_defaults();
      t_modes();
      t_rate();
      t_select();
      report_and_stop();
   end

   // Whole run takes a few thousand nanoseconds
   initial
   begin
      #50000;
      mismatches++;
      report_and_stop();
   end
endmodule // deser_port_select_tb_top

// file: verif/serializer_model.sv
// Behavioural remote camera serializer feeding one deserializer input
`timescale 1ns/1ps
module serializer_model
   import deser_pkg::*;
(
   input  wire logic                          sys_clk,
   input  wire logic                          reset,
   input  wire logic                          send,
   input  wire logic [deser_pkg::PAY_W-1:0]   payload,
   input  wire logic [1:0]                    ctl,
   output logic [deser_pkg::FRAME_W-1:0]      frame,
   output logic                               vld
);
   import deser_pkg::*;

   logic [FRAME_W-1:0] prev_r;
   logic [FRAME_W-1:0] word;
   logic [FRAME_W-1:0] scr;

   //--------------------
   // Frame coding
   //--------------------
   always_comb
   begin
      word = {2'b00, ctl, payload};
      // Invert heavy words so the line stays balanced
      if ($countones(word[25:0]) > 13)
      begin
         word = {2'b10, ~word[25:0]};
      end
      word[FR_PAR_BIT] = ^word[25:0];
      scr = word ^ {prev_r[13:0], prev_r[27:14]};
   end

   //--------------------
   // Line driver
   //--------------------
   // send_frame spaces sends three cycles apart to stay under the line ceiling; t_rate holds send for four back-to-back frames
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         prev_r <= '0;
         frame  <= '0;
         vld    <= 1'b0;
      end
      else if (send)
      begin
         prev_r <= scr;
         frame  <= scr;
         vld    <= 1'b1;
      end
      else
      begin
         // Idle line inverts every bit each cycle, so it shows the last frame again every second idle cycle
         frame <= ~frame;
         vld   <= 1'b0;
      end
   end
endmodule // serializer_model
